//--- hw/ads_antenna_select.v
// Function
// - dual mode acquisition toggles antenna each dwell
// - after verify, hold receiver's chosen antenna
// - half duplex plus transmit enable releases hold
// - receive enable rising restarts acquisition
// - receive enable low keeps last antenna
// - early receive disable in dual mode drives best stored antenna
// - incomplete dwell keeps last completed quality
// - chip reset clears stored quality values
// - receive low resets toggle; high then low
// - first dwell uses antenna B in dual mode only
// - header mode 00 SFD, 01 adds CRC16
`timescale 1ns/1ps
`default_nettype none
`include "ads_defines.vh"

module ads_antenna_select #(
	parameter SQ_W      = 8,
	parameter DWELL_CYC = `ADS_FIRST_DWELL_CYC
) (
	input  wire            ref_clk_i,
	input  wire            reset_i,
	input  wire            chip_reset_n_i,
	input  wire            dual_antenna_i,
	input  wire            half_duplex_i,
	input  wire            receive_power_enable_i,
	input  wire            transmit_power_enable_i,
	input  wire            verify_i,
	input  wire            verify_ant_i,
	input  wire            dwell_done_i,
	input  wire [SQ_W-1:0] signal_quality_metric_i,
	input  wire [1:0]      rx_header_mode_i,
	output reg             antenna_choice_out_o,
	output reg             acquiring_o,
	output reg             expect_crc_o,
	output reg             expect_length_o,
	output reg             expect_full_header_o
);

	localparam ST_IDLE = 2'd0;
	localparam ST_ACQ  = 2'd1;
	localparam ST_HOLD = 2'd2;

	localparam CW = 16;

	reg  [1:0]    state_q;
	reg  [1:0]    state_d;
	reg           rxpe_q;
	reg           toggle_q;
	reg           toggle_d;
	reg           ant_d;
	reg  [CW-1:0] dwell_cnt_q;
	reg  [CW-1:0] dwell_cnt_d;
	wire          best_ant;
	wire          rx_rise;
	wire          tx_release;
	wire          dwell_end;
	wire          dwell_store;
	wire [2:0]    hdr_sel;

	////////////////////////////////////////////////////////////////////////
	// header mode decode

	function [2:0] hdr_fields;
		input [1:0] mode;
		begin
			case (mode)
				`ADS_HDR_SFD:         hdr_fields = 3'h0;
				`ADS_HDR_SFD_CRC:     hdr_fields = 3'h1;
				`ADS_HDR_SFD_CRC_LEN: hdr_fields = 3'h3;
				`ADS_HDR_FULL:        hdr_fields = 3'h7;
				default:              hdr_fields = 3'h0;
			endcase
		end
	endfunction

	assign hdr_sel = hdr_fields(rx_header_mode_i[`ADS_HDR_MODE_MSB:`ADS_HDR_MODE_LSB]);

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			expect_crc_o         <= 1'b0;
			expect_length_o      <= 1'b0;
			expect_full_header_o <= 1'b0;
		end else begin
			expect_crc_o         <= hdr_sel[0];
			expect_length_o      <= hdr_sel[1];
			expect_full_header_o <= hdr_sel[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quality store

	ads_quality_store #(
		.SQ_W(SQ_W)
	) u_store (
		.ref_clk_i               (ref_clk_i),
		.reset_i                 (reset_i),
		.chip_reset_n_i          (chip_reset_n_i),
		.dwell_done_i            (dwell_store),
		.dwell_ant_i             (antenna_choice_out_o),
		.signal_quality_metric_i (signal_quality_metric_i),
		.best_ant_o              (best_ant),
		.quality_a_o             (),
		.quality_b_o             ()
	);

	////////////////////////////////////////////////////////////////////////
	// control

	assign rx_rise    = receive_power_enable_i && !rxpe_q;
	assign tx_release = half_duplex_i && transmit_power_enable_i;
	// a dwell ends on the timer or on the receiver's own dwell strobe
	assign dwell_end  = (state_q == ST_ACQ) && dual_antenna_i &&
	                    (dwell_done_i || (dwell_cnt_q == DWELL_CYC[CW-1:0] - 16'h0001));
	// only a dwell the receiver completed carries a valid quality value
	assign dwell_store = dwell_end && dwell_done_i;

	always @* begin
		state_d     = state_q;
		toggle_d    = toggle_q;
		ant_d       = antenna_choice_out_o;
		dwell_cnt_d = dwell_cnt_q;
		case (state_q)
			ST_IDLE: begin
				toggle_d = 1'b0;
				if (rx_rise) begin
					state_d     = ST_ACQ;
					toggle_d    = `ADS_ANT_B;
					ant_d       = dual_antenna_i ? `ADS_ANT_B : antenna_choice_out_o;
					dwell_cnt_d = 16'h0000;
				end
			end
			ST_ACQ: begin
				if (!receive_power_enable_i) begin
					state_d = ST_IDLE;
					// toggle reset leaves last antenna unless dual mode picks the best
					if (dual_antenna_i)
						ant_d = best_ant;
				end else if (verify_i) begin
					state_d = ST_HOLD;
					ant_d   = verify_ant_i;
				end else if (dwell_end) begin
					toggle_d    = ~toggle_q;
					ant_d       = ~toggle_q;
					dwell_cnt_d = 16'h0000;
				end else begin
					dwell_cnt_d = dwell_cnt_q + 16'h0001;
				end
			end
			ST_HOLD: begin
				if (!receive_power_enable_i)
					state_d = ST_IDLE;
				else if (tx_release)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		// a fresh rise restarts acquisition from any state
		if (rx_rise && state_q != ST_IDLE) begin
			state_d     = ST_ACQ;
			toggle_d    = `ADS_ANT_B;
			ant_d       = dual_antenna_i ? `ADS_ANT_B : antenna_choice_out_o;
			dwell_cnt_d = 16'h0000;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q              <= ST_IDLE;
			rxpe_q               <= 1'b0;
			toggle_q             <= 1'b0;
			antenna_choice_out_o <= `ADS_ANT_A;
			dwell_cnt_q          <= 16'h0000;
			acquiring_o          <= 1'b0;
		end else begin
			state_q              <= state_d;
			rxpe_q               <= receive_power_enable_i;
			toggle_q             <= toggle_d;
			antenna_choice_out_o <= ant_d;
			dwell_cnt_q          <= dwell_cnt_d;
			acquiring_o          <= (state_d == ST_ACQ);
		end
	end

endmodule // ads_antenna_select
`default_nettype wire

//--- hw/ads_defines.vh
`ifndef ADS_DEFINES_VH
`define ADS_DEFINES_VH

// clock period in picoseconds (40 MHz)
`define ADS_CLK_PERIOD_PS      25000
// antenna choice must rise within this time of receive_power_enable rising
`define ADS_FIRST_HIGH_NS      50
// the first dwell (antenna B) lasts about this long before toggling
`define ADS_FIRST_DWELL_NS     135
// cycles: least time rounds up, longest rounds down
`define ADS_FIRST_DWELL_CYC    ((`ADS_FIRST_DWELL_NS*1000+`ADS_CLK_PERIOD_PS-1)/`ADS_CLK_PERIOD_PS)
`define ADS_FIRST_HIGH_CYC     ((`ADS_FIRST_HIGH_NS*1000)/`ADS_CLK_PERIOD_PS)

// antenna encoding on the choice output
`define ADS_ANT_A              1'b0
`define ADS_ANT_B              1'b1

// receive header mode field position and codes
`define ADS_HDR_MODE_MSB       1
`define ADS_HDR_MODE_LSB       0
`define ADS_HDR_SFD            2'h0
`define ADS_HDR_SFD_CRC        2'h1
`define ADS_HDR_SFD_CRC_LEN    2'h2
`define ADS_HDR_FULL           2'h3

// reset value of a stored quality value
`define ADS_SQ_RESET           8'h00

`endif

//--- hw/ads_quality_store.v
`timescale 1ns/1ps
`default_nettype none
`include "ads_defines.vh"

// holds the last completed-dwell quality value for each antenna
module ads_quality_store #(
	parameter SQ_W = 8
) (
	input  wire            ref_clk_i,
	input  wire            reset_i,
	input  wire            chip_reset_n_i,
	input  wire            dwell_done_i,
	input  wire            dwell_ant_i,
	input  wire [SQ_W-1:0] signal_quality_metric_i,
	output wire            best_ant_o,
	output wire [SQ_W-1:0] quality_a_o,
	output wire [SQ_W-1:0] quality_b_o
);

	reg [SQ_W-1:0] sq_q [0:1];

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sq
			always @(posedge ref_clk_i) begin
				if (reset_i || !chip_reset_n_i)
					sq_q[g] <= {SQ_W{1'b0}};
				else if (dwell_done_i && (dwell_ant_i == g))
					sq_q[g] <= signal_quality_metric_i;
			end
		end
	endgenerate

	assign quality_a_o = sq_q[0];
	assign quality_b_o = sq_q[1];
	// ties favour antenna B, the one dwelt on first
	assign best_ant_o  = (sq_q[0] > sq_q[1]) ? `ADS_ANT_A : `ADS_ANT_B;

endmodule // ads_quality_store
`default_nettype wire

//--- sim/ads_antenna_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ads_antenna_select_sva (
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	input wire logic       dual_antenna_i,
	input wire logic       receive_power_enable_i,
	input wire logic       verify_i,
	input wire logic       verify_ant_i,
	input wire logic       dwell_done_i,
	input wire logic [1:0] rx_header_mode_i,
	input wire logic       antenna_choice_out_o,
	input wire logic       acquiring_o,
	input wire logic       expect_crc_o,
	input wire logic       expect_length_o,
	input wire logic       expect_full_header_o
);
	wire       rx = receive_power_enable_i;
	wire       an = antenna_choice_out_o;
	wire       du = dual_antenna_i;
	wire [1:0] md = rx_header_mode_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	a_rise_b: assert property (du && $rose(rx) && !$past(reset_i) |=> an && acquiring_o)
		else $error("rise did not pick B");
	a_idle_hold: assert property (!rx && !acquiring_o |=> $stable(an))
		else $error("idle antenna moved");
	a_verify_hold: assert property (acquiring_o && verify_i && rx && du |=> an == $past(verify_ant_i))
		else $error("verify not held");
	a_dwell_tog: assert property (acquiring_o && du && rx && dwell_done_i && !verify_i |=> an != $past(an))
		else $error("no toggle");
	a_hdr_crc: assert property (1 |=> expect_crc_o == ($past(md) != 2'h0))
		else $error("crc decode");
	a_hdr_len: assert property (1 |=> expect_length_o == $past(md[1]))
		else $error("length decode");
	a_hdr_full: assert property (1 |=> expect_full_header_o == &$past(md))
		else $error("full decode");
	// first dwell ends on the timer alone when the receiver stays quiet
	a_first_dwell: assert property (du && $rose(rx) && !$past(reset_i) ##1 (rx && du && !dwell_done_i && !verify_i)[*8] |-> !an && $past(an, 4))
		else $error("first dwell timing");
endmodule // ads_antenna_select_sva
bind ads_antenna_select ads_antenna_select_sva ads_sva_inst (.*);
`default_nettype wire

//--- sim/ads_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ends a dwell every fourth cycle, before the timer; quality scrambles when not valid
module ads_rx_model (
	input wire logic       clk_i,
	input wire logic       en_i,
	input wire logic       ant_i,
	input wire logic [7:0] qa_i,
	input wire logic [7:0] qb_i,
	output logic           dwell_done_o,
	output logic     [7:0] sq_o
);
	logic [1:0] cnt_q = 2'h0;
	always @(posedge clk_i) begin
		cnt_q <= en_i ? cnt_q + 2'h1 : 2'h0;
		dwell_done_o <= en_i && cnt_q == 2'h3;
		sq_o <= (en_i && cnt_q == 2'h3) ? (ant_i ? qb_i : qa_i) : ~sq_o;
	end
endmodule // ads_rx_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst = 1, crst_n = 0, du = 1, hd = 0, rx = 0, tx = 0, vf = 0, va = 0, mq = 0;
	logic [1:0] md = 2'h0;
	logic [7:0] qa = 8'h00, qb = 8'h00, sq;
	logic       dd, an, acq, ec, el, ef;
	int         bad_count = 0, comparisons = 0, i;
	initial forever #12.5 clk = ~clk;
	ads_antenna_select ads_antenna_select_inst (.ref_clk_i(clk), .reset_i(rst),
		.chip_reset_n_i(crst_n), .dual_antenna_i(du), .half_duplex_i(hd),
		.receive_power_enable_i(rx), .transmit_power_enable_i(tx), .verify_i(vf),
		.verify_ant_i(va), .dwell_done_i(dd), .signal_quality_metric_i(sq),
		.rx_header_mode_i(md), .antenna_choice_out_o(an), .acquiring_o(acq),
		.expect_crc_o(ec), .expect_length_o(el), .expect_full_header_o(ef));
	ads_rx_model ads_rx_model_inst (.clk_i(clk), .en_i(rx && !mq), .ant_i(an), .qa_i(qa),
		.qb_i(qb), .dwell_done_o(dd), .sq_o(sq));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ties go to antenna B
	function automatic logic best(input logic [7:0] a, input logic [7:0] b);
		return b >= a;
	endfunction
	task tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// cleared: no dwell completed since the stores were cleared, so both are zero (tie, B)
	task automatic acq_run(input int n, input bit cleared);
		@(posedge clk); rx <= 1;
		@(posedge clk); @(negedge clk); cmp(an, 8'h01);
		repeat (n) @(posedge clk); rx <= 0;
		@(posedge clk); @(negedge clk); cmp(an, cleared ? 8'h01 : best(qa, qb));
	endtask
	initial begin #100us; bad_count++; tally_and_finish; end
	initial begin
		void'($urandom(79));
		repeat (10) @(posedge clk);
		rst <= 0; crst_n <= 1;
		for (i = 0; i < 4; i++) begin
			@(posedge clk); md <= i[1:0];
			@(posedge clk); @(negedge clk); cmp({ec, el, ef}, {i != 0, i[1], i == 3});
		end
		$display("header test done");
		for (i = 0; i < 20; i++) begin
			@(posedge clk); qa <= 8'($urandom); qb <= 8'($urandom);
			acq_run(20, 0);
			repeat (3) @(negedge clk); cmp(an, best(qa, qb));
		end
		$display("random acquisition test done");
		@(posedge clk); rx <= 1; hd <= 1;
		repeat (3) @(posedge clk); vf <= 1; va <= 0;
		@(posedge clk); vf <= 0;
		repeat (6) @(negedge clk); cmp(an, 8'h00);
		@(posedge clk); tx <= 1;
		repeat (2) @(negedge clk); cmp({acq, an}, 8'h00);
		@(posedge clk); tx <= 0; rx <= 0; hd <= 0;
		$display("verify test done");
		@(posedge clk); qa <= 8'hFF; qb <= 8'h01;
		acq_run(20, 0);
		@(posedge clk); crst_n <= 0;
		@(posedge clk); crst_n <= 1;
		acq_run(1, 1);
		$display("chip reset test done");
		@(posedge clk); mq <= 1; rx <= 1;
		repeat (7) @(posedge clk);
		@(negedge clk); cmp(an, 8'h00);
		repeat (3) @(posedge clk); rx <= 0;
		@(posedge clk); mq <= 0; du <= 0;
		repeat (2) @(posedge clk); rx <= 1;
		repeat (12) @(negedge clk); cmp(an, 8'h01);
		$display("timer and single antenna test done");
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
